/* core/slt_pattern_gen.sv */
// Link test pattern generator with a classic Wishbone register slave.
// Assumes adv_i pulses once per frame, symbol or octet of the chosen point.
// How it works
// R1: Host writes soft reset command when returning mode to zero; it self-clears.
// R2: Sample test bit set: transport samples equal the raw converter samples.
// R3: Four-bit mode field picks the pattern; zero passes normal data.
// R4: Checkerboard alternates 5555/aaaa; toggle alternates 0000/ffff, first word listed first.
// R5: Mode 3 is PN31 with its seed, mode 4 PRBS_TWENTY_THREE with its seed.
// R6: Modes 5, 6, 7 are PN15, PN9 and PN7 with their seeds.
// R7: Ramp adds one per word, wraps at 2^16, trimmed to point width.
// R8: Repeat user mode cycles user patterns one to four forever.
// R9: Single user mode sends patterns one to four once, then zeros.
// R10: Two-bit point field injects at sample, 10-bit or 8-bit input.
// R11: Sample point: same word on all converters and samples, one step per frame.
// R12: 10-bit point: one step per symbol, ten-bit words, user bits 15:6.
// R13: 8-bit point: one step per octet, eight-bit words, user bits 15:9.
// R14: Three-bit link layer test field is held and driven to the link layer.
// R15: Host disables sync request input through the sync register before link tests.
// R16: Each mode change reloads PN seeds so the first word repeats.
module slt_pattern_gen (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Data path
  input wire logic adv_i,
  input wire logic [63:0] frame_i,
  input wire logic [9:0] phy_i,
  input wire logic [7:0] scr_i,
  output logic [63:0] frame_o,
  output logic [9:0] phy_o,
  output logic [7:0] scr_o,
  // Link side controls
  output logic tpl_test_o,
  output logic [7:0] sync_ctl_o,
  output logic [2:0] dll_mode_o
);

  typedef struct packed {
    logic ack;
    logic [7:0] rdat;
    logic srst;
    logic [7:0] tpl;
    logic [7:0] sync;
    logic [7:0] mode;
    logic [7:0] dll;
    logic [63:0] up;
    logic [3:0] mode_q;
    logic phase;
    logic [15:0] ramp;
    logic [1:0] uidx;
    logic udone;
    logic [30:0] lfsr;
    logic [63:0] fo;
    logic [9:0] po;
    logic [7:0] so;
  } slt_state_t;

  slt_state_t s;
  slt_state_t n;
  logic [13:0] idx;
  logic [7:0] rd;
  logic [3:0] md;
  logic [1:0] pt;
  logic act;
  logic reload;
  logic [4:0] w;
  logic [15:0] pw;
  logic [15:0] u;
  logic [46:0] pn_res;
  logic [2:0] ub;

  assign idx = adr_i[15:2];
  assign md = s.mode[slt_pkg::MODE_LSB+:4];
  assign pt = s.mode[slt_pkg::POINT_LSB+:2];
  assign act = (md != slt_pkg::M_OFF) && (pt != 2'h3); // R3 R10
  assign reload = (md != s.mode_q) || s.srst; // R16
  assign ub = 3'(idx - slt_pkg::IX_UP_FIRST);

  always_comb begin
    case (pt)
      slt_pkg::P_SAMPLE: w = slt_pkg::W_SAMPLE;
      slt_pkg::P_PHY: w = slt_pkg::W_PHY;
      default: w = slt_pkg::W_SCR;
    endcase
  end

  // Register read mux; command register has no read entry, so it reads zero
  always_comb begin
    rd = 8'h00;
    if (idx >= slt_pkg::IX_UP_FIRST && idx <= slt_pkg::IX_UP_LAST) begin
      rd = s.up[{ub, 3'h0}+:8];
    end else begin
      case (idx)
        slt_pkg::IX_TPL: rd = s.tpl;
        slt_pkg::IX_SYNC: rd = s.sync;
        slt_pkg::IX_MODE: rd = s.mode;
        slt_pkg::IX_DLL: rd = s.dll;
        default: rd = 8'h00;
      endcase
    end
  end

  // Pattern word, low w bits valid
  always_comb begin
    pn_res = slt_pkg::pn_word(s.lfsr, md, w); // R5 R6
    u = s.up[{s.uidx, 4'h0}+:16];
    case (md)
      slt_pkg::M_CHK: pw = s.phase ? slt_pkg::CHK_ALT : slt_pkg::CHK_WORD; // R4
      slt_pkg::M_TOG: pw = s.phase ? slt_pkg::TOG_ONES : 16'h0000; // R4
      slt_pkg::M_RAMP: pw = s.ramp; // R7
      slt_pkg::M_PRBS_THIRTY_ONE, slt_pkg::M_PRBS_TWENTY_THREE, slt_pkg::M_PRBS_FIFTEEN,
      slt_pkg::M_PRBS_NINE, slt_pkg::M_PRBS_SEVEN: begin
        pw = pn_res[46:31];
      end
      slt_pkg::M_UREP, slt_pkg::M_USGL: begin
        case (pt)
          slt_pkg::P_PHY: pw = {6'h00, u[15:6]}; // R12
          slt_pkg::P_SCR: pw = {9'h000, u[15:9]}; // R13
          default: pw = u;
        endcase
        if (md == slt_pkg::M_USGL && s.udone) pw = 16'h0000; // R9
      end
      default: pw = 16'h0000;
    endcase
    if (pt == slt_pkg::P_PHY) pw = pw & slt_pkg::MASK_PHY; // R12
    if (pt == slt_pkg::P_SCR) pw = pw & slt_pkg::MASK_SCR; // R13
  end

  always_comb begin
    n = s;
    n.ack = 1'b0;
    n.srst = 1'b0; // R1
    if (cyc_i && stb_i && !s.ack) begin
      n.ack = 1'b1;
      n.rdat = rd;
      if (we_i && sel_i[0]) begin
        if (idx >= slt_pkg::IX_UP_FIRST && idx <= slt_pkg::IX_UP_LAST) begin
          n.up[{ub, 3'h0}+:8] = dat_i[7:0];
        end else begin
          case (idx)
            slt_pkg::IX_CFG: n.srst = (dat_i[7:0] == slt_pkg::SOFT_RESET_CMD); // R1
            slt_pkg::IX_TPL: n.tpl = dat_i[7:0];
            slt_pkg::IX_SYNC: n.sync = dat_i[7:0];
            slt_pkg::IX_MODE: n.mode = dat_i[7:0];
            slt_pkg::IX_DLL: n.dll = dat_i[7:0];
            default: n.rdat = rd;
          endcase
        end
      end
    end
    n.mode_q = md;
    // Reload beats advance so the first word after a change is fixed
    if (reload) begin
      n.phase = 1'b0;
      n.ramp = 16'h0000;
      n.uidx = 2'h0;
      n.udone = 1'b0;
      n.lfsr = slt_pkg::pn_seed(md); // R16
    end else if (act && adv_i) begin
      n.phase = ~s.phase; // R4
      n.ramp = s.ramp + 16'h0001; // R7
      n.uidx = s.uidx + 2'h1; // R8
      // Only single mode latches the end; repeat mode must keep cycling
      if (md == slt_pkg::M_USGL && s.uidx == slt_pkg::LAST_USER) n.udone = 1'b1; // R9
      n.lfsr = pn_res[30:0];
    end
    n.fo = frame_i; // R2 R3
    n.po = phy_i;
    n.so = scr_i;
    if (act && pt == slt_pkg::P_SAMPLE) begin
      n.fo = (adv_i && !reload) ? {4{pw}} : s.fo; // R11
    end
    if (act && pt == slt_pkg::P_PHY) begin
      n.po = (adv_i && !reload) ? pw[9:0] : s.po; // R10 R12
    end
    if (act && pt == slt_pkg::P_SCR) begin
      n.so = (adv_i && !reload) ? pw[7:0] : s.so; // R10 R13
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign ack_o = s.ack;
  assign dat_o = {24'h000000, s.rdat};
  assign frame_o = s.fo;
  assign phy_o = s.po;
  assign scr_o = s.so;
  assign tpl_test_o = s.tpl[slt_pkg::TPL_EN_BIT]; // R2
  assign sync_ctl_o = s.sync;
  assign dll_mode_o = s.dll[slt_pkg::DLL_LSB+:3]; // R14

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held two cycles");
  chk_srst_clear: assert property (s.srst |=> !s.srst) // R1
    else $error("soft reset did not self clear");
  chk_raw_pass: assert property (!act |=> frame_o == $past(frame_i) && phy_o == $past(phy_i)) // R2
    else $error("raw samples not passed through");
  chk_off_scr: assert property (md == slt_pkg::M_OFF |=> scr_o == $past(scr_i)) // R3
    else $error("off mode altered scrambler data");
  chk_chk_sample: assert property (act && pt == 2'h0 && md == slt_pkg::M_CHK && adv_i
      && !reload |=> frame_o[15:0] == ($past(s.phase) ? 16'haaaa : 16'h5555)) // R4
    else $error("checkerboard word wrong");
  chk_seed_load: assert property (md != s.mode_q |=> s.lfsr == slt_pkg::pn_seed($past(md))) // R16
    else $error("seed not loaded on mode change");
  chk_ramp_step: assert property (act && md == slt_pkg::M_RAMP && adv_i && !reload
      |=> s.ramp == $past(s.ramp) + 16'h0001) // R7
    else $error("ramp did not step by one");
  chk_user_cycle: assert property (act && md == slt_pkg::M_UREP && adv_i && !reload
      |=> s.uidx == $past(s.uidx) + 2'h1 && !s.udone) // R8
    else $error("repeat user index wrong");
  chk_single_zero: assert property (act && pt == 2'h0 && md == slt_pkg::M_USGL && s.udone
      && adv_i && !reload |=> frame_o == 64'h0) // R9
    else $error("single user mode not zero after four");
  chk_frame_same: assert property (act && pt == 2'h0 && adv_i && !reload
      |=> frame_o == {4{frame_o[15:0]}}) // R11
    else $error("frame words differ");
  chk_phy_toggle: assert property (act && pt == 2'h1 && md == slt_pkg::M_TOG && adv_i
      && !reload |=> phy_o == ($past(s.phase) ? 10'h3ff : 10'h000)) // R12
    else $error("ten-bit toggle wrong");
  chk_scr_checker: assert property (act && pt == 2'h2 && md == slt_pkg::M_CHK && adv_i
      && !reload |=> scr_o == ($past(s.phase) ? 8'haa : 8'h55)) // R13
    else $error("octet checkerboard wrong");
  chk_dll_field: assert property (ack_o && $past(we_i && sel_i[0] && idx == 14'h0574)
      |-> dll_mode_o == $past(dat_i[2:0])) // R14
    else $error("link test field not updated");

endmodule

/* core/slt_pkg.sv */
// Constants, codes and PN helpers for the link test pattern generator.
// Assumes a Wishbone slave with registers at word index times four.
package slt_pkg;

  // Register indices; byte address is four times the index
  localparam logic [13:0] IX_CFG = 14'h0000;
  localparam logic [13:0] IX_UP_FIRST = 14'h0551;
  localparam logic [13:0] IX_UP_LAST = 14'h0558;
  localparam logic [13:0] IX_TPL = 14'h0571;
  localparam logic [13:0] IX_SYNC = 14'h0572;
  localparam logic [13:0] IX_MODE = 14'h0573;
  localparam logic [13:0] IX_DLL = 14'h0574;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] SOFT_RESET_CMD = 8'h81;

  // Field positions
  localparam int TPL_EN_BIT = 5;
  localparam int MODE_LSB = 0;
  localparam int POINT_LSB = 4;
  localparam int DLL_LSB = 0;

  // Word shapes
  localparam logic [15:0] CHK_WORD = 16'h5555;
  localparam logic [15:0] CHK_ALT = 16'haaaa;
  localparam logic [15:0] TOG_ONES = 16'hffff;
  localparam logic [15:0] MASK_PHY = 16'h03ff;
  localparam logic [15:0] MASK_SCR = 16'h00ff;
  localparam logic [4:0] W_SAMPLE = 5'h10;
  localparam logic [4:0] W_PHY = 5'h0a;
  localparam logic [4:0] W_SCR = 5'h08;
  localparam logic [1:0] LAST_USER = 2'h3;

  // Seeds
  localparam logic [30:0] SEED_31 = 31'h0003afff;
  localparam logic [30:0] SEED_23 = 31'h00003aff;
  localparam logic [30:0] SEED_15 = 31'h000003af;
  localparam logic [30:0] SEED_9 = 31'h00000092;
  localparam logic [30:0] SEED_7 = 31'h00000007;

  typedef enum logic [3:0] {
    M_OFF = 4'h0,
    M_CHK = 4'h1,
    M_TOG = 4'h2,
    M_PRBS_THIRTY_ONE = 4'h3,
    M_PRBS_TWENTY_THREE = 4'h4,
    M_PRBS_FIFTEEN = 4'h5,
    M_PRBS_NINE = 4'h6,
    M_PRBS_SEVEN = 4'h7,
    M_RAMP = 4'h8,
    M_UREP = 4'he,
    M_USGL = 4'hf
  } slt_mode_t;

  typedef enum logic [1:0] {
    P_SAMPLE = 2'h0,
    P_PHY = 2'h1,
    P_SCR = 2'h2
  } slt_point_t;

  function automatic logic [30:0] pn_seed(input logic [3:0] md);
    case (md)
      M_PRBS_THIRTY_ONE: pn_seed = SEED_31;
      M_PRBS_TWENTY_THREE: pn_seed = SEED_23;
      M_PRBS_FIFTEEN: pn_seed = SEED_15;
      M_PRBS_NINE: pn_seed = SEED_9;
      M_PRBS_SEVEN: pn_seed = SEED_7;
      default: pn_seed = 31'h0;
    endcase
  endfunction

  // Returns {word, next state}; emits w bits, first bit in the word's MSB
  function automatic logic [46:0] pn_word(input logic [30:0] st, input logic [3:0] md,
                                          input logic [4:0] w);
    logic [30:0] v;
    logic [15:0] wd;
    logic fb;
    int len;
    int tap;
    v = st;
    wd = 16'h0;
    fb = 1'b0;
    len = 31;
    tap = 28;
    case (md)
      M_PRBS_TWENTY_THREE: begin len = 23; tap = 18; end
      M_PRBS_FIFTEEN: begin len = 15; tap = 14; end
      M_PRBS_NINE: begin len = 9; tap = 5; end
      M_PRBS_SEVEN: begin len = 7; tap = 6; end
      default: begin len = 31; tap = 28; end
    endcase
    for (int i = 0; i < 16; i++) begin
      if (i < int'(w)) begin
        fb = v[len-1] ^ v[tap-1];
        v = {v[29:0], fb};
        wd = {wd[14:0], fb};
      end
    end
    for (int j = 0; j < 31; j++) begin
      if (j >= len) v[j] = 1'b0;
    end
    pn_word = {wd, v};
  endfunction

endpackage

/* verif/slt_rx_model.sv */
// Far-side model: raw data source and word-request strobe.
// Assumes the bench pulses req_i for one cycle per wanted word.
module slt_rx_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench control
  input wire logic req_i,
  input wire logic slow_i,
  // Toward the generator; done_o goes to the bench
  output logic adv_o,
  output logic done_o,
  output logic [63:0] frame_o,
  output logic [9:0] phy_o,
  output logic [7:0] scr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend;
  logic [2:0] wait_q;
  // Raw data moves every cycle so a stale pass-through shows
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {pend, wait_q, adv_o, done_o} <= '0;
      {frame_o, phy_o, scr_o} <= '0;
    end else begin
      frame_o <= frame_o + 64'h0123456789abcdef;
      phy_o <= phy_o + 10'h001;
      scr_o <= scr_o + 8'h03;
      done_o <= adv_o;
      adv_o <= 1'b0;
      if (req_i) begin
        pend <= 1'b1;
        wait_q <= slow_i ? 3'h4 : 3'h0;
      end else if (pend && wait_q == 3'h0) begin
        pend <= 1'b0;
        adv_o <= 1'b1;
      end else if (pend) begin
        wait_q <= wait_q - 3'h1;
      end
    end
  end
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the link test pattern generator.
// Assumes the far-side model in slt_rx_model supplies raw data and strobes.
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] md; logic [15:0] a; logic [15:0] b;} slt_row_t;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, req_i = 0, slow_i = 0;
  logic [15:0] adr_i = 16'h0000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic ack_o, adv_i, tpl_test_o, done_o;
  logic [63:0] frame_i, frame_o, fsave;
  logic [9:0] phy_i, phy_o, psave;
  logic [7:0] scr_i, scr_o, ssave, sync_ctl_o;
  logic [2:0] dll_mode_o;
  logic [15:0] e;
  int err_total = 0, tests_run = 0;
  slt_row_t rows [8] = '{'{8'h01, 16'h5555, 16'haaaa}, '{8'h02, 16'h0000, 16'hffff},
    '{8'h11, 16'h0155, 16'h02aa}, '{8'h12, 16'h0000, 16'h03ff}, '{8'h21, 16'h0055, 16'h00aa},
    '{8'h22, 16'h0000, 16'h00ff}, '{8'h08, 16'h0000, 16'h0001}, '{8'h28, 16'h0002, 16'h0003}};
  logic [15:0] up [4] = '{16'hc3a5, 16'h5a3c, 16'h0ff0, 16'hf00f};
  // Mode nibble differs row to row so each entry restarts the user index
  logic [7:0] um [3] = '{8'h1f, 8'h2e, 8'h0f};
  int pl [5] = '{31, 23, 15, 9, 7};
  int pt [5] = '{28, 18, 14, 5, 6};
  logic [30:0] ps [5] = '{31'h0003afff, 31'h00003aff, 31'h000003af, 31'h00000092, 31'h00000007};

  always #2 clk_i = ~clk_i;

  slt_pattern_gen dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .adv_i(adv_i), .frame_i(frame_i), .phy_i(phy_i), .scr_i(scr_i), .frame_o(frame_o),
    .phy_o(phy_o), .scr_o(scr_o), .tpl_test_o(tpl_test_o), .sync_ctl_o(sync_ctl_o),
    .dll_mode_o(dll_mode_o));
  slt_rx_model rx_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .slow_i(slow_i),
    .adv_o(adv_i), .done_o(done_o), .frame_o(frame_i), .phy_o(phy_i), .scr_o(scr_i));

  // Reference PN words, first bit lands in the word's top bit
  function automatic logic [15:0] pn_ref(int len, int tap, logic [30:0] s, int w, int k);
    logic [15:0] wd;
    logic b;
    for (int n = 0; n <= k; n++) begin
      wd = 16'h0;
      for (int i = 0; i < w; i++) begin
        b = s[len-1] ^ s[tap-1];
        s = {s[29:0], b};
        wd = {wd[14:0], b};
      end
    end
    return wd;
  endfunction

  task automatic wb(input logic w, input logic [13:0] ix, input logic [7:0] d,
                    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, 4'h1};
    adr_i <= {ix, 2'b00};
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
    if (n >= 50) err_total++;
  endtask

  // One word request; the far side may answer late
  task automatic step();
    int n;
    n = 0;
    @(posedge clk_i);
    req_i <= 1'b1;
    @(posedge clk_i);
    req_i <= 1'b0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (done_o !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
  endtask

  task automatic chk_word(input logic [1:0] p, input logic [15:0] x);
    if (p == 2'h0) `CHK("frame", {4{x}}, frame_o)
    else if (p == 2'h1) `CHK("phy", x[9:0], phy_o)
    else `CHK("scr", x[7:0], scr_o)
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    wrap_up();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, slt_pkg::IX_MODE, 8'h00, q);
    `CHK("mode_rst", 32'h0, q)
    foreach (rows[i]) begin
      wb(1'b1, slt_pkg::IX_MODE, rows[i].md, q);
      step();
      chk_word(rows[i].md[5:4], rows[i].a);
      step();
      chk_word(rows[i].md[5:4], rows[i].b);
    end
    // Second pass with a slow far side proves the seeds reload
    for (int r = 0; r < 2; r++) begin
      slow_i <= r[0];
      for (int m = 0; m < 5; m++) begin
        wb(1'b1, slt_pkg::IX_MODE, 8'h13 + 8'(m), q);
        for (int k = 0; k < 2; k++) begin
          step();
          chk_word(2'h1, pn_ref(pl[m], pt[m], ps[m], 10, k));
        end
      end
    end
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, 14'h551 + 14'(2 * k), up[k][7:0], q);
      wb(1'b1, 14'h552 + 14'(2 * k), up[k][15:8], q);
    end
    wb(1'b0, 14'h557, 8'h00, q);
    `CHK("up4_lo", 32'h0000000f, q)
    foreach (um[u]) begin
      wb(1'b1, slt_pkg::IX_MODE, um[u], q);
      for (int k = 0; k < 6; k++) begin
        e = (um[u][0] && k > 3) ? 16'h0 : up[k % 4];
        e = um[u][5] ? {9'h0, e[15:9]} : (um[u][4] ? {6'h0, e[15:6]} : e);
        step();
        chk_word(um[u][5:4], e);
      end
    end
    wb(1'b1, slt_pkg::IX_MODE, 8'h01, q);
    step();
    wb(1'b1, 14'h000, 8'h81, q);
    step();
    chk_word(2'h0, 16'h5555);
    wb(1'b1, slt_pkg::IX_MODE, 8'h00, q);
    wb(1'b1, 14'h000, 8'h81, q);
    wb(1'b0, 14'h000, 8'h00, q);
    `CHK("cfg", 32'h0, q)
    wb(1'b1, slt_pkg::IX_TPL, 8'h20, q);
    `CHK("tpl", 1'b1, tpl_test_o)
    #1;
    {fsave, psave, ssave} = {frame_i, phy_i, scr_i};
    @(posedge clk_i);
    #1;
    `CHK("pass", {fsave, psave, ssave}, {frame_o, phy_o, scr_o})
    wb(1'b1, slt_pkg::IX_SYNC, 8'hc0, q);
    `CHK("sync", 8'hc0, sync_ctl_o)
    wb(1'b1, slt_pkg::IX_DLL, 8'h05, q);
    `CHK("dll", 3'h5, dll_mode_o)
    wb(1'b1, 14'h0123, 8'h5a, q);
    wb(1'b0, 14'h0123, 8'h00, q);
    `CHK("unmapped", 32'h0, q)
    // Mid-run reset clears every register
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK("dll_rst", 3'h0, dll_mode_o)
    `CHK("sync_rst", 8'h00, sync_ctl_o)
    `CHK("tpl_rst", 1'b0, tpl_test_o)
    wb(1'b0, slt_pkg::IX_MODE, 8'h00, q);
    `CHK("mode_rst2", 32'h0, q)
    wrap_up();
  end
endmodule
